/* include/sheet_ctrl_params.svh */
// timing counts, field positions and register map of the sheet controller
`ifndef SHEET_CTRL_PARAMS_SVH
`define SHEET_CTRL_PARAMS_SVH
`define CLK_HZ 200000000
`define ENTRY_PULSES 12
`define ENTRY_SPAN_MS 10000
`define PULSE_MIN_MS 100
`define ADJ_MIN_MS 10000
`define ADJ_EXIT_MS 15000
`define FLASH_HALF_MS 250
`define ENTRY_SPAN_CYC ((`CLK_HZ / 1000) * `ENTRY_SPAN_MS)
`define PULSE_MIN_CYC ((`CLK_HZ / 1000) * `PULSE_MIN_MS)
`define ADJ_MIN_CYC ((`CLK_HZ / 1000) * `ADJ_MIN_MS)
`define ADJ_EXIT_CYC ((`CLK_HZ / 1000) * `ADJ_EXIT_MS)
`define FLASH_HALF_CYC ((`CLK_HZ / 1000) * `FLASH_HALF_MS)
`define OP_TOO_CLOSE 7'h01
`define OP_TOO_FAR 7'h63
`define OP_LOW_OK 7'h1e
`define OP_HIGH_OK 7'h5a
`define ERR_CAL_CODE 7'h0a
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_CALVAL 4'h8
`define REG_ERR 4'hc
`define CTRL_CAP_SEL 0
`define CTRL_REF_OK 1
`endif

/* include/sheet_ctrl_pkg.sv */
// types shared by the sheet controller
package sheet_ctrl_pkg;
	typedef enum logic [1:0] {
		LVL_HIGH,
		LVL_INSUFF,
		LVL_WEAK,
		LVL_VWEAK
	} us_level_t;
	typedef enum {
		ST_IDLE,
		ST_ADJ,
		ST_ADJ_END,
		ST_CAL
	} ctrl_state_t;
endpackage : sheet_ctrl_pkg

/* hdl/sheet_ctrl.sv */
// control sequencer: adjustment, calibration and activation of the tester
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sheet_ctrl_params.svh"

module sheet_ctrl
	import sheet_ctrl_pkg::*;
#(
	parameter int unsigned ENTRY_SPAN_CYC = `ENTRY_SPAN_CYC,
	parameter int unsigned ADJ_MIN_CYC = `ADJ_MIN_CYC,
	parameter int unsigned ADJ_EXIT_CYC = `ADJ_EXIT_CYC,
	parameter int unsigned PULSE_MIN_CYC = `PULSE_MIN_CYC,
	parameter int unsigned FLASH_HALF_CYC = `FLASH_HALF_CYC
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic cal_in,
	input wire logic act_in,
	input wire logic inq1_in,
	input wire logic cap_present,
	input wire logic [6:0] cap_point,
	input wire logic [1:0] us_level,
	input wire logic sheet_one,
	input wire logic sheet_two,
	input wire logic [15:0] ref_sample,
	input wire logic nv_valid,
	input wire logic [15:0] nv_cal_value,
	input wire logic nv_cap_mode,
	output logic nv_we,
	output logic [15:0] nv_wr_value,
	output logic nv_wr_cap_mode,
	output logic self_test,
	output logic ready_out,
	output logic error_out,
	output logic dbl_out,
	output logic first_sheet_out,
	output logic act_led,
	output logic lamp_yellow,
	output logic lamp_green,
	output logic [6:0] disp_value,
	output logic disp_blank
);

	localparam int unsigned W = 32;

	ctrl_state_t state_q;
	ctrl_state_t state_d;
	logic [2:0] pin_now;
	logic [2:0] pin_q;

	logic [W-1:0] span_q;
	logic [W-1:0] tmr_q;
	logic [W-1:0] hi_q;
	logic [W-1:0] flash_q;
	logic [3:0] pulses_q;

	logic cap_used_q;
	logic calibrated_q;
	logic err_q;
	logic dbl_q;
	logic blink_q;
	logic loaded_q;
	logic [15:0] cal_val_q;
	logic [6:0] err_code_q;
	logic sw_cap_sel_q;
	logic sw_ref_ok_q;
	logic ack_q;
	logic [1:0] first_q;

	function automatic logic adj_state(input ctrl_state_t s);
		case (s)
			ST_ADJ: adj_state = 1'b1;
			ST_ADJ_END: adj_state = 1'b1;
			default: adj_state = 1'b0;
		endcase
	endfunction : adj_state

	// one flop per pin gives the previous level for edge detection
	assign pin_now = {inq1_in, act_in, cal_in};
	wire cal_rise = cal_in & ~pin_q[0];
	wire cal_fall = ~cal_in & pin_q[0];
	wire act_rise = act_in & ~pin_q[1];
	wire act_fall = ~act_in & pin_q[1];
	wire inq_rise = inq1_in & ~pin_q[2];
	// a span running out on a rising edge restarts the count at one
	wire span_over = (pulses_q != 4'h0) && (span_q >= ENTRY_SPAN_CYC - 1);
	wire long_hi = cal_fall && (hi_q >= PULSE_MIN_CYC);
	// the twelfth rising edge itself enters, without waiting for its fall
	wire entry_hit = (state_q == ST_IDLE) && cal_rise && !span_over
		&& (pulses_q == 4'(`ENTRY_PULSES - 1));

	wire adj_mode = adj_state(state_q);
	wire adj_scan = state_q == ST_ADJ;
	wire cal_step = state_q == ST_CAL;
	wire adj_exit = (state_q == ST_ADJ_END) && (state_d == ST_IDLE);
	// accepted operating band of the capacitive sensor
	wire cap_ok = cap_present && (cap_point > `OP_LOW_OK - 7'h01)
		&& (cap_point < `OP_HIGH_OK + 7'h01);
	// reference check can be forced to fail from software
	wire ref_good = sw_ref_ok_q && (ref_sample != 16'h0000);
	wire cal_write = cal_step && ref_good;
	// only the first pulse of a span calibrates, so a burst calibrates at its first pulse
	wire cal_start = (state_q == ST_IDLE) && long_hi && !act_in
		&& (pulses_q <= 4'h1);

	// avalon decode
	wire bus_req = (avs_read | avs_write) & ~ack_q;
	wire hit_ctrl = avs_address == `REG_CTRL;
	// a write lands only on the edge that ends the access, one cycle after the wait state
	wire wr_ctrl = avs_write & ack_q & hit_ctrl;

	function automatic logic [31:0] rd_mux(input logic [3:0] a);
		case (a)
			`REG_CTRL: rd_mux = {30'h0, sw_ref_ok_q, sw_cap_sel_q};
			`REG_STATUS: rd_mux = {24'h0, pulses_q, dbl_q, err_q,
				calibrated_q, cap_used_q};
			`REG_CALVAL: rd_mux = {16'h0, cal_val_q};
			`REG_ERR: rd_mux = {25'h0, err_code_q};
			default: rd_mux = 32'h0;
		endcase
	endfunction : rd_mux

	// one wait state on every access keeps the read path registered
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_q <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			ack_q <= bus_req;
			if (bus_req && avs_read) begin
				avs_readdata <= rd_mux(avs_address);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sw_cap_sel_q <= 1'b1;
			sw_ref_ok_q <= 1'b1;
		end else if (wr_ctrl) begin
			sw_cap_sel_q <= avs_writedata[`CTRL_CAP_SEL];
			sw_ref_ok_q <= avs_writedata[`CTRL_REF_OK];
		end
	end

	// input stages reset to the idle level, so no false edge after reset
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pin
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					pin_q[gi] <= 1'b0;
				end else begin
					pin_q[gi] <= pin_now[gi];
				end
			end
		end
	endgenerate

	// high time of the calibration pulse
	// saturates so a stuck input cannot wrap into a false short pulse
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hi_q <= '0;
		end else if (!cal_in) begin
			hi_q <= '0;
		end else if (hi_q != '1) begin
			hi_q <= hi_q + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pulses_q <= 4'h0;
			span_q <= '0;
		// calibration keeps the count, so a burst still reaches twelve
		end else if (adj_mode || entry_hit) begin
			pulses_q <= 4'h0;
			span_q <= '0;
		end else if (span_over) begin
			pulses_q <= cal_rise ? 4'h1 : 4'h0;
			span_q <= '0;
		end else if (cal_rise) begin
			pulses_q <= pulses_q + 4'h1;
			span_q <= (pulses_q == 4'h0) ? '0 : span_q + 1'b1;
		end else if (pulses_q != 4'h0) begin
			span_q <= span_q + 1'b1;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (entry_hit) begin
					state_d = ST_ADJ;
				end else if (cal_start) begin
					state_d = ST_CAL;
				end
			end
			// ten second minimum
			// an early closing pulse is ignored
			ST_ADJ: begin
				if (cal_rise && tmr_q >= ADJ_MIN_CYC - 1) begin
					state_d = ST_ADJ_END;
				end
			end
			ST_ADJ_END: begin
				if (tmr_q >= ADJ_EXIT_CYC - 1) begin
					state_d = ST_IDLE;
				end
			end
			// calibration result is taken in a single cycle
			ST_CAL: begin
				state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// reset leaves adjustment
	// the timer restarts on every change of state
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
			tmr_q <= '0;
		end else begin
			state_q <= state_d;
			tmr_q <= (state_d != state_q) ? '0 : tmr_q + 1'b1;
		end
	end

	assign self_test = adj_scan && (tmr_q == '0);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			loaded_q <= 1'b0;
			calibrated_q <= 1'b0;
			cal_val_q <= 16'h0;
			cap_used_q <= 1'b0;
			err_q <= 1'b0;
			err_code_q <= 7'h0;
		end else begin
			// storage is read once, on the first edge after reset
			loaded_q <= 1'b1;
			if (!loaded_q) begin
				calibrated_q <= nv_valid;
				cal_val_q <= nv_cal_value;
				cap_used_q <= nv_cap_mode;
			end else if (self_test) begin
				cap_used_q <= cap_present && sw_cap_sel_q;
			end else if (adj_exit) begin
				cap_used_q <= cap_used_q && cap_ok;
				// a new sensor set invalidates the stored reference
				calibrated_q <= 1'b0;
			end else if (cal_step) begin
				calibrated_q <= ref_good;
				err_q <= !ref_good;
				err_code_q <= ref_good ? 7'h0 : `ERR_CAL_CODE;
				if (ref_good) begin
					cal_val_q <= ref_sample;
				end
			end else if (cal_rise || act_rise) begin
				err_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			nv_we <= 1'b0;
			nv_wr_value <= 16'h0;
			nv_wr_cap_mode <= 1'b0;
		end else begin
			nv_we <= cal_write;
			nv_wr_value <= ref_sample;
			nv_wr_cap_mode <= cap_used_q;
		end
	end

	// classify and latch double
	// a latched double sheet blocks further inquiries
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dbl_q <= 1'b0;
			first_q <= 2'b00;
		end else if (act_fall) begin
			dbl_q <= 1'b0;
		end else if (act_in && calibrated_q && !dbl_q && inq_rise) begin
			dbl_q <= sheet_two;
			first_q <= {1'b1, sheet_one && !sheet_two};
		end
	end

	// one blink for lamps and error code, so both flash in step
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			flash_q <= '0;
			blink_q <= 1'b0;
		end else if (flash_q >= FLASH_HALF_CYC - 1) begin
			flash_q <= '0;
			blink_q <= ~blink_q;
		end else begin
			flash_q <= flash_q + 1'b1;
		end
	end

	// activation indicator
	// follows the pin directly; an open input reads low
	assign act_led = act_in;
	assign ready_out = calibrated_q && !err_q && !dbl_q && !adj_mode;
	assign error_out = err_q && !adj_mode;
	assign dbl_out = dbl_q && !adj_mode;
	assign first_sheet_out = first_q[0] && !adj_mode;

	wire lvl_high = us_level == LVL_HIGH;
	wire lvl_insuff = us_level == LVL_INSUFF;
	wire lvl_vweak = us_level == LVL_VWEAK;
	assign lamp_yellow = adj_scan && (lvl_vweak ? blink_q : 1'b1);
	assign lamp_green = adj_scan ?
		(lvl_high || (lvl_insuff && blink_q)) : 1'b1;

	wire op_over = !cap_present || (cap_point > `OP_TOO_FAR);
	wire [6:0] op_shown = op_over ? `OP_TOO_FAR : cap_point;
	assign disp_value = adj_mode ? op_shown : err_code_q;
	// error code flashes; display dark with nothing to report
	assign disp_blank = adj_mode ? 1'b0 : (!err_q || blink_q);

endmodule : sheet_ctrl

/* testbench/machine_ctrl_model.sv */
// machine controller model driving calibration and inquiry lines
`timescale 1ns/1ps
module machine_ctrl_model #(
	parameter int HOLD = 12
) (
	input wire logic sys_clk,
	output logic cal_in,
	output logic inq1_in
);
	initial begin
		cal_in = 1'b0;
		inq1_in = 1'b0;
	end
	task automatic pulse(input int n);
		repeat (n) begin
			cal_in <= 1'b1;
			repeat (HOLD) @(posedge sys_clk);
			cal_in <= 1'b0;
			repeat (HOLD) @(posedge sys_clk);
		end
	endtask : pulse
	task automatic inquire();
		inq1_in <= 1'b1;
		repeat (4) @(posedge sys_clk);
		inq1_in <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : inquire
endmodule : machine_ctrl_model

/* testbench/sheet_ctrl_assertions.sv */
// port assertions of the sheet controller
`timescale 1ns/1ps
module sheet_ctrl_checker (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic avs_read,
	input wire logic avs_waitrequest,
	input wire logic act_in,
	input wire logic [1:0] us_level,
	input wire logic self_test,
	input wire logic nv_we,
	input wire logic ready_out,
	input wire logic error_out,
	input wire logic dbl_out,
	input wire logic act_led,
	input wire logic lamp_yellow,
	input wire logic lamp_green,
	input wire logic [6:0] disp_value,
	input wire logic disp_blank
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	act_lamp_a: assert property (act_led == act_in)
		else $error("activation lamp off input");
	test_pulse_a: assert property (self_test |=> !self_test)
		else $error("self test longer than one cycle");
	cal_idle_a: assert property ($rose(ready_out) |-> !act_in)
		else $error("ready rose while activated");
	ready_err_a: assert property (!(ready_out && error_out))
		else $error("ready and error together");
	dbl_hold_a: assert property ($fell(dbl_out) |-> !act_in)
		else $error("double sheet cleared while activated");
	store_once_a: assert property (nv_we |=> !nv_we)
		else $error("storage write longer than one cycle");
	level_high_a: assert property (lamp_yellow && us_level == 2'h0 &&
		$past(us_level) == 2'h0 |-> lamp_green)
		else $error("high level without green");
	level_weak_a: assert property (lamp_yellow && us_level[1] &&
		$past(us_level[1]) |-> !lamp_green)
		else $error("weak level with green");
	point_range_a: assert property (!disp_blank |-> disp_value <= 7'h63)
		else $error("display above 99");
	bus_wait_a: assert property ($rose(avs_read) |->
		avs_waitrequest ##1 !avs_waitrequest)
		else $error("read not answered after one wait");
endmodule : sheet_ctrl_checker
bind sheet_ctrl sheet_ctrl_checker sheet_ctrl_checker_inst (.sys_clk, .arst_n,
	.avs_read, .avs_waitrequest, .act_in, .us_level, .self_test, .nv_we,
	.ready_out, .error_out, .dbl_out, .act_led, .lamp_yellow, .lamp_green,
	.disp_value, .disp_blank);

/* testbench/sheet_ctrl_tb_top.sv */
// self-checking bench for the sheet controller
`timescale 1ns/1ps
module sheet_ctrl_tb_top;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic act_in = 1'b0;
	logic [6:0] cap_point = 7'h2d;
	logic [1:0] us_level = 2'h0;
	logic sheet_one = 1'b0;
	logic sheet_two = 1'b0;
	logic nv_valid = 1'b0;
	logic cap_present = 1'b1;
	logic [15:0] ref_sample = 16'h5a5a;
	logic [15:0] nv_cal = 16'h1234;
	logic nv_cap_mode = 1'b0;
	logic cal_in, inq1_in, avs_waitrequest, self_test, ready_out, error_out;
	logic dbl_out, first_sheet_out, act_led, lamp_yellow, lamp_green, nv_we;
	logic disp_blank;
	logic [31:0] avs_readdata, rd;
	logic [15:0] nv_val;
	logic [6:0] disp_value;
	int error_cnt = 0, n_checks = 0, cyc = 0, st_cnt = 0, we_cnt = 0;
	sheet_ctrl #(.ENTRY_SPAN_CYC(400), .ADJ_MIN_CYC(100), .ADJ_EXIT_CYC(150),
		.PULSE_MIN_CYC(10), .FLASH_HALF_CYC(8)) sheet_ctrl_inst (.sys_clk,
		.arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .cal_in, .act_in, .inq1_in,
		.cap_present, .cap_point, .us_level, .sheet_one, .sheet_two,
		.ref_sample, .nv_valid, .nv_cal_value(nv_cal),
		.nv_cap_mode, .nv_we, .nv_wr_value(nv_val), .nv_wr_cap_mode(),
		.self_test, .ready_out, .error_out, .dbl_out, .first_sheet_out,
		.act_led, .lamp_yellow, .lamp_green, .disp_value, .disp_blank);
	machine_ctrl_model machine_ctrl_model_inst (.sys_clk, .cal_in, .inq1_in);
	initial forever #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		st_cnt = st_cnt + int'(self_test);
		we_cnt = we_cnt + int'(nv_we);
		if (cyc == 6000) begin
			error_cnt = error_cnt + 1;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic cal(input int n);
		machine_ctrl_model_inst.pulse(n);
	endtask : cal
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : idle
	task automatic do_reset();
		arst_n <= 1'b0;
		idle(2);
		arst_n <= 1'b1;
		idle(2);
	endtask : do_reset
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	initial begin
		do_reset();
		chk({ready_out, error_out, lamp_green, disp_blank}, 4'h3);
		bus(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h3);
		bus(1'b0, 4'h2, 32'h0);
		chk(rd, 32'h0);
		act_in <= 1'b1;
		cal(1);
		chk({act_led, ready_out}, 2'b10);
		act_in <= 1'b0;
		idle(410);
		cal(1);
		chk({ready_out, error_out, nv_val}, 18'h25a5a);
		chk(we_cnt, 1);
		bus(1'b0, 4'h8, 32'h0);
		chk(rd, 32'h5a5a);
		$display("test calibration done");
		act_in <= 1'b1;
		sheet_one <= 1'b1;
		machine_ctrl_model_inst.inquire();
		chk({first_sheet_out, dbl_out}, 2'b10);
		sheet_two <= 1'b1;
		machine_ctrl_model_inst.inquire();
		chk(dbl_out, 1'b1);
		sheet_one <= 1'b0;
		sheet_two <= 1'b0;
		machine_ctrl_model_inst.inquire();
		chk(dbl_out, 1'b1);
		act_in <= 1'b0;
		idle(3);
		chk(dbl_out, 1'b0);
		$display("test sheets done");
		cal(5);
		idle(420);
		bus(1'b0, 4'h4, 32'h0);
		chk({rd[7:4], 4'(st_cnt)}, 8'h00);
		$display("test entry timeout done");
		cal(12);
		chk(st_cnt, 1);
		cal(1);
		for (int i = 0; i < 4; i++) begin
			us_level <= 2'(i);
			idle(3);
			if (i != 3) chk(lamp_yellow, 1'b1);
			if (i != 1) chk(lamp_green, i == 0);
		end
		idle(3);
		chk({disp_blank, disp_value}, 8'h2d);
		cap_point <= 7'h78;
		idle(3);
		chk(disp_value, 7'h63);
		idle(150);
		chk(lamp_yellow, 1'b1);
		cal(1);
		idle(160);
		chk({lamp_yellow, lamp_green, ready_out}, 3'b010);
		$display("test adjustment done");
		idle(410);
		bus(1'b1, 4'h0, 32'h1);
		cal(1);
		chk({ready_out, error_out}, 2'b01);
		bus(1'b0, 4'hc, 32'h0);
		chk(rd, 32'h0a);
		nv_valid <= 1'b1;
		do_reset();
		chk(ready_out, 1'b1);
		bus(1'b0, 4'h8, 32'h0);
		chk(rd, 32'h1234);
		$display("test failure and restore done");
		results();
	end
endmodule : sheet_ctrl_tb_top
